// file: pkg/iob_io_defines.svh
// address map, field layouts and reset values for the i/o bit access unit
`ifndef IOB_IO_DEFINES_SVH
`define IOB_IO_DEFINES_SVH

// i/o locations reachable by the short i/o transfers
`define IOB_IO_LAST        6'h3F
// i/o locations reachable by single-bit set, clear and skip
`define IOB_BIT_IO_LAST    6'h1F
// data-space address of i/o location 0x00
`define IOB_DATA_IO_BASE   8'h20
// first data-space address above the i/o and extended i/o regions
`define IOB_DATA_IO_END    9'h100
// full-byte write mask and idle byte
`define IOB_MASK_ALL       8'hFF
`define IOB_BYTE_ZERO      8'h00

// local flag registers: data-space address, write-one-to-clear bits, reset value
`define IOB_FLAG0_ADDR     8'h34
`define IOB_FLAG0_W1C      8'hFF
`define IOB_FLAG0_RESET    8'h00
`define IOB_FLAG1_ADDR     8'h35
`define IOB_FLAG1_W1C      8'hF0
`define IOB_FLAG1_RESET    8'h00

`endif

// file: pkg/iob_pkg.sv
// types shared by the i/o bit access unit
package iob_pkg;

  typedef enum logic [2:0] {
    IOB_IO_READ,
    IOB_IO_WRITE,
    IOB_SET_IO_BIT_OP,
    IOB_CLEAR_IO_BIT_OP,
    IOB_SKIP_IF_IO_BIT_ONE,
    IOB_SKIP_IF_IO_BIT_ZERO,
    IOB_DIRECT_DATA_LOAD,
    IOB_DIRECT_DATA_STORE
  } iob_op_e;

  typedef enum logic {
    IOB_IDLE,
    IOB_ACCESS
  } iob_state_e;

endpackage

// file: rtl/iob_flag_cell.sv
// one 8-bit i/o register with per-bit write-one-to-clear status flags
`timescale 1ns/1ps
`default_nettype none

module iob_flag_cell
#(
  parameter logic [7:0] W1C_MASK = 8'hFF,
  parameter logic [7:0] RESET_VAL = 8'h00
)
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] wmask_i,
  input  wire logic [7:0] event_i,
  output logic      [7:0] q_o
);

  logic [7:0] q_reg;
  logic [7:0] q_next;
  logic [7:0] hit;

  assign hit = wr_i ? wmask_i : 8'h00;

  // w1c bits: written one clears, zero keeps, a same-cycle event wins over the clear
  // plain bits: masked write stores, events do not touch them
  always_comb
  begin
    q_next = ((q_reg & ~(hit & wdata_i)) | event_i) & W1C_MASK;
    q_next = q_next | (((hit & wdata_i) | (~hit & q_reg)) & ~W1C_MASK);
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_reg <= RESET_VAL;
    else
      q_reg <= q_next;
  end

  assign q_o = q_reg;

  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_chk
      if (W1C_MASK[b])
      begin : g_w1c
        w1c_clear_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
          wr_i && wmask_i[b] && wdata_i[b] && !event_i[b] |=> !q_reg[b])
          else $error("flag not cleared by written one");
        w1c_keep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
          wr_i && wmask_i[b] && !wdata_i[b] |=> q_reg[b] == $past(q_reg[b]) || $past(event_i[b]))
          else $error("flag changed by written zero");
      end
    end
  endgenerate

endmodule

`default_nettype wire

// file: rtl/iob_io_bit_access.sv
// access unit for the low i/o space: byte transfers, single-bit set/clear and bit skip tests
//
// Operation
// - bit set and clear work at i/o 0x00..0x1F only, refused above
// - in the bit range, test one bit and skip when set or clear
// - some status flags clear on a written one; a written zero keeps them
// - bit set/clear changes only the addressed bit; others masked off
`timescale 1ns/1ps
`default_nettype none
`include "iob_io_defines.svh"

module iob_io_bit_access
  import iob_pkg::*;
(
  input  wire logic           core_clk_i,
  input  wire logic           rst_n_i,
  input  wire logic           req_valid_i,
  output logic                req_ready_o,
  input  wire iob_op_e        req_op_i,
  input  wire logic [15:0]    req_addr_i,
  input  wire logic [2:0]     req_bit_i,
  input  wire logic [7:0]     req_wdata_i,
  output logic                rsp_valid_o,
  output logic                rsp_err_o,
  output logic                rsp_skip_o,
  output logic [7:0]          rsp_rdata_o,
  output logic                per_wr_o,
  output logic                per_rd_o,
  output logic [7:0]          per_addr_o,
  output logic [7:0]          per_wdata_o,
  output logic [7:0]          per_wmask_o,
  input  wire logic [7:0]     per_rdata_i,
  input  wire logic [1:0][7:0] flag_event_i,
  output logic [1:0][7:0]     flag_q_o
);

  localparam logic [1:0][7:0] FLAG_ADDR = {`IOB_FLAG1_ADDR, `IOB_FLAG0_ADDR};

  iob_state_e  state_reg;
  iob_op_e     op_reg;
  logic [7:0]  loc_reg;
  logic [7:0]  loc_next;
  logic [2:0]  bit_reg;
  logic [7:0]  wdata_reg;
  logic [7:0]  wdata_next;
  logic [7:0]  wmask_reg;
  logic [7:0]  wmask_next;
  logic        legal_reg;
  logic        legal_next;
  logic        rsp_valid_reg;
  logic        rsp_err_reg;
  logic        rsp_skip_reg;
  logic [7:0]  rsp_rdata_reg;
  logic        accept;
  logic        is_io;
  logic        is_bit;
  logic        is_direct;
  logic [7:0]  onehot;
  logic        acc_wr;
  logic        acc_rd;
  logic [1:0]  flag_hit;
  logic [7:0]  rd_mux;
  logic        bit_val;

  assign req_ready_o = (state_reg == IOB_IDLE);
  assign accept      = req_valid_i && req_ready_o;
  assign onehot      = 8'h01 << req_bit_i;

  assign is_io     = (req_op_i == IOB_IO_READ) || (req_op_i == IOB_IO_WRITE);
  assign is_bit    = (req_op_i == IOB_SET_IO_BIT_OP) || (req_op_i == IOB_CLEAR_IO_BIT_OP)
                     || (req_op_i == IOB_SKIP_IF_IO_BIT_ONE)
                     || (req_op_i == IOB_SKIP_IF_IO_BIT_ZERO);
  assign is_direct = (req_op_i == IOB_DIRECT_DATA_LOAD) || (req_op_i == IOB_DIRECT_DATA_STORE);

  // decode of the request into a data-space location, legality and byte lanes
  always_comb
  begin
    legal_next = 1'b0;
    loc_next   = req_addr_i[7:0];
    wmask_next = `IOB_MASK_ALL;
    wdata_next = req_wdata_i;
    if (is_direct)
    begin
      // extended i/o lives only in data space; the register file below it is not ours
      legal_next = (req_addr_i >= 16'(`IOB_DATA_IO_BASE))
                   && (req_addr_i < 16'(`IOB_DATA_IO_END));
    end
    else if (is_io)
    begin
      loc_next   = {2'b00, req_addr_i[5:0]} + `IOB_DATA_IO_BASE;
      legal_next = (req_addr_i <= 16'(`IOB_IO_LAST));
    end
    else if (is_bit)
    begin
      loc_next   = {2'b00, req_addr_i[5:0]} + `IOB_DATA_IO_BASE;
      legal_next = (req_addr_i <= 16'(`IOB_BIT_IO_LAST));
      // only the addressed lane is enabled; a clear writes zero there, so no
      // written one can reach a neighbouring write-one-to-clear flag
      wmask_next = onehot;
      wdata_next = (req_op_i == IOB_SET_IO_BIT_OP) ? onehot : `IOB_BYTE_ZERO;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_reg <= IOB_IDLE;
    else
    begin
      case (state_reg)
        IOB_IDLE:
          if (accept)
            state_reg <= IOB_ACCESS;
        IOB_ACCESS:
          state_reg <= IOB_IDLE;
        default:
          state_reg <= IOB_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_reg    <= IOB_IO_READ;
      loc_reg   <= `IOB_BYTE_ZERO;
      bit_reg   <= 3'h0;
      wdata_reg <= `IOB_BYTE_ZERO;
      wmask_reg <= `IOB_BYTE_ZERO;
      legal_reg <= 1'b0;
    end
    else if (accept)
    begin
      op_reg    <= req_op_i;
      loc_reg   <= loc_next;
      bit_reg   <= req_bit_i;
      wdata_reg <= wdata_next;
      wmask_reg <= wmask_next;
      legal_reg <= legal_next;
    end
  end

  // refused requests never reach the registers
  assign acc_wr = (state_reg == IOB_ACCESS) && legal_reg
                  && ((op_reg == IOB_IO_WRITE) || (op_reg == IOB_DIRECT_DATA_STORE)
                      || (op_reg == IOB_SET_IO_BIT_OP) || (op_reg == IOB_CLEAR_IO_BIT_OP));
  assign acc_rd = (state_reg == IOB_ACCESS) && legal_reg
                  && ((op_reg == IOB_IO_READ) || (op_reg == IOB_DIRECT_DATA_LOAD)
                      || (op_reg == IOB_SKIP_IF_IO_BIT_ONE)
                      || (op_reg == IOB_SKIP_IF_IO_BIT_ZERO));

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_flag
      assign flag_hit[g] = (loc_reg == FLAG_ADDR[g]);
      iob_flag_cell
      #(
        .W1C_MASK  ((g == 0) ? `IOB_FLAG0_W1C : `IOB_FLAG1_W1C),
        .RESET_VAL ((g == 0) ? `IOB_FLAG0_RESET : `IOB_FLAG1_RESET)
      )
      u_flag
      (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .wr_i       (acc_wr && flag_hit[g]),
        .wdata_i    (wdata_reg),
        .wmask_i    (wmask_reg),
        .event_i    (flag_event_i[g]),
        .q_o        (flag_q_o[g])
      );
    end
  endgenerate

  // local flag registers shadow the peripheral port at their own addresses
  assign per_wr_o    = acc_wr && (flag_hit == 2'b00);
  assign per_rd_o    = acc_rd && (flag_hit == 2'b00);
  assign per_addr_o  = loc_reg;
  assign per_wdata_o = wdata_reg;
  assign per_wmask_o = wmask_reg;

  assign rd_mux  = flag_hit[0] ? flag_q_o[0] : (flag_hit[1] ? flag_q_o[1] : per_rdata_i);
  assign bit_val = rd_mux[bit_reg];

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsp_valid_reg <= 1'b0;
      rsp_err_reg   <= 1'b0;
      rsp_skip_reg  <= 1'b0;
      rsp_rdata_reg <= `IOB_BYTE_ZERO;
    end
    else
    begin
      rsp_valid_reg <= (state_reg == IOB_ACCESS);
      if (state_reg == IOB_ACCESS)
      begin
        rsp_err_reg   <= !legal_reg;
        rsp_rdata_reg <= acc_rd ? rd_mux : `IOB_BYTE_ZERO;
        rsp_skip_reg  <= acc_rd && (((op_reg == IOB_SKIP_IF_IO_BIT_ONE) && bit_val)
                         || ((op_reg == IOB_SKIP_IF_IO_BIT_ZERO) && !bit_val));
      end
    end
  end

  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_err_o   = rsp_err_reg;
  assign rsp_skip_o  = rsp_skip_reg;
  assign rsp_rdata_o = rsp_rdata_reg;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  bit_range_a: assert property (
    accept && is_bit && (req_addr_i > 16'(`IOB_BIT_IO_LAST))
    |-> ##1 (!per_wr_o && !per_rd_o) ##1 (rsp_valid_o && rsp_err_o && !rsp_skip_o))
    else $error("bit operation performed above bit range");

  bit_ok_a: assert property (
    // flag_hit still belongs to the previous access here, so the new location is decoded
    accept && (req_op_i == IOB_SET_IO_BIT_OP) && (req_addr_i <= 16'(`IOB_BIT_IO_LAST))
    && (loc_next != `IOB_FLAG0_ADDR) && (loc_next != `IOB_FLAG1_ADDR)
    |-> ##1 per_wr_o ##1 (rsp_valid_o && !rsp_err_o))
    else $error("legal bit set not performed");

  single_lane_a: assert property (
    per_wr_o && ((op_reg == IOB_SET_IO_BIT_OP) || (op_reg == IOB_CLEAR_IO_BIT_OP))
    |-> $onehot(per_wmask_o) && (per_wmask_o == (8'h01 << bit_reg))
        && ((per_wdata_o & ~per_wmask_o) == `IOB_BYTE_ZERO))
    else $error("bit operation touches other lanes");

  clear_zero_a: assert property (
    per_wr_o && (op_reg == IOB_CLEAR_IO_BIT_OP) |-> (per_wdata_o == `IOB_BYTE_ZERO))
    else $error("bit clear writes a one");

  skip_test_a: assert property (
    (state_reg == IOB_ACCESS) && legal_reg && (op_reg == IOB_SKIP_IF_IO_BIT_ONE)
    |=> rsp_valid_o && (rsp_skip_o == $past(rd_mux[bit_reg])))
    else $error("skip decision does not follow tested bit");

  io_alias_a: assert property (
    accept && is_io && (req_addr_i <= 16'(`IOB_IO_LAST))
    |=> per_addr_o == 8'({2'b00, $past(req_addr_i[5:0])} + `IOB_DATA_IO_BASE))
    else $error("i/o location not mapped at data address plus offset");

  ext_io_a: assert property (
    accept && is_io && (req_addr_i > 16'(`IOB_IO_LAST)) |-> ##2 (rsp_valid_o && rsp_err_o))
    else $error("extended location reached by short i/o transfer");

  rsp_time_a: assert property (
    accept |-> ##1 !req_ready_o ##1 (rsp_valid_o && req_ready_o))
    else $error("response not two cycles after accept");

  set_cov_c:   cover property (accept && (req_op_i == IOB_SET_IO_BIT_OP) ##2 !rsp_err_o);
  skip_cov_c:  cover property (rsp_valid_o && rsp_skip_o);
  err_cov_c:   cover property (rsp_valid_o && rsp_err_o);
  flag_cov_c:  cover property (acc_wr && (flag_hit != 2'b00));

endmodule

`default_nettype wire

// file: tb/iob_per_model.sv
// peripheral register space model behind the access unit
`timescale 1ns/1ps
`default_nettype none

module iob_per_model
(
  input  wire logic       core_clk_i,
  input  wire logic       per_wr_i,
  input  wire logic       per_rd_i,
  input  wire logic [7:0] per_addr_i,
  input  wire logic [7:0] per_wdata_i,
  input  wire logic [7:0] per_wmask_i,
  output logic      [7:0] per_rdata_o
);
  logic [7:0] mem [256];

  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
  end

  // only masked lanes change, so a lone bit write cannot disturb neighbours
  always @(posedge core_clk_i)
  begin
    if (per_wr_i)
      mem[per_addr_i] <= (mem[per_addr_i] & ~per_wmask_i) | (per_wdata_i & per_wmask_i);
  end

  // outside a read the bus shows junk, not the last byte
  assign per_rdata_o = per_rd_i ? mem[per_addr_i] : ~mem[per_addr_i];
endmodule

`default_nettype wire

// file: tb/test_iob_io_bit_access.sv
// self-checking bench for the i/o bit access unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end

module test_iob_io_bit_access
  import iob_pkg::*;
;
  logic            clk, rst_n, req_valid, req_ready, rsp_valid, rsp_err, rsp_skip;
  logic            per_wr, per_rd, c_wr, c_rd;
  iob_op_e         req_op;
  logic [15:0]     req_addr;
  logic [2:0]      req_bit;
  logic [7:0]      req_wdata, rsp_rdata, per_addr, per_wdata, per_wmask, per_rdata;
  logic [7:0]      c_addr, c_mask, c_wdata;
  logic [1:0][7:0] flag_event, flag_q;
  int              n_errors, checks_done;

  iob_io_bit_access DUT (.core_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_op_i(req_op), .req_addr_i(req_addr), .req_bit_i(req_bit),
    .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err),
    .rsp_skip_o(rsp_skip), .rsp_rdata_o(rsp_rdata), .per_wr_o(per_wr), .per_rd_o(per_rd),
    .per_addr_o(per_addr), .per_wdata_o(per_wdata), .per_wmask_o(per_wmask),
    .per_rdata_i(per_rdata), .flag_event_i(flag_event), .flag_q_o(flag_q));

  iob_per_model PER (.core_clk_i(clk), .per_wr_i(per_wr), .per_rd_i(per_rd),
    .per_addr_i(per_addr), .per_wdata_i(per_wdata), .per_wmask_i(per_wmask),
    .per_rdata_o(per_rdata));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one request; the access cycle is captured, the response checked one cycle later
  task automatic xfer(input iob_op_e op, input logic [15:0] a, input int b,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_addr  <= a;
    req_bit   <= 3'(b);
    req_wdata <= d;
    #1;
    while (req_ready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_errors++;
        report_and_stop();
      end
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    {c_wr, c_rd, c_addr, c_mask, c_wdata} = {per_wr, per_rd, per_addr, per_wmask, per_wdata};
    @(posedge clk);
    #1;
    `CHK(rsp_valid, 1'b1)
  endtask

  task automatic set_clear_bits();
    logic [7:0] ios [3] = '{8'h00, 8'h05, 8'h1F};
    foreach (ios[i])
    begin
      xfer(IOB_IO_WRITE, {8'h00, ios[i]}, 0, 8'h5A);
      for (int b = 0; b < 8; b += 3)
      begin
        xfer(IOB_SET_IO_BIT_OP, {8'h00, ios[i]}, b, 8'hFF);
        `CHK(c_addr, ios[i] + 8'h20)
        `CHK({c_wr, rsp_err, c_mask, c_wdata}, {2'b10, 8'h01 << b, 8'h01 << b})
        xfer(IOB_CLEAR_IO_BIT_OP, {8'h00, ios[i]}, b, 8'hFF);
        `CHK({c_wr, rsp_err, c_mask, c_wdata}, {2'b10, 8'h01 << b, 8'h00})
      end
      xfer(IOB_IO_READ, {8'h00, ios[i]}, 0, 8'h00);
      `CHK(rsp_rdata, 8'h12)
    end
  endtask

  task automatic bit_ops_refused();
    iob_op_e ops [4] = '{IOB_SET_IO_BIT_OP, IOB_CLEAR_IO_BIT_OP,
                         IOB_SKIP_IF_IO_BIT_ONE, IOB_SKIP_IF_IO_BIT_ZERO};
    foreach (ops[i])
    begin
      xfer(ops[i], 16'h0020, 2, 8'h00);
      `CHK({rsp_err, c_wr, c_rd, rsp_skip}, 4'h8)
    end
  endtask

  task automatic skip_tests();
    logic [7:0] v = 8'h5A;
    xfer(IOB_IO_WRITE, 16'h0007, 0, v);
    for (int b = 0; b < 8; b++)
    begin
      xfer(IOB_SKIP_IF_IO_BIT_ONE, 16'h0007, b, 8'h00);
      `CHK({c_rd, c_addr, rsp_skip, rsp_err}, {1'b1, 8'h27, v[b], 1'b0})
      xfer(IOB_SKIP_IF_IO_BIT_ZERO, 16'h0007, b, 8'h00);
      `CHK({c_rd, rsp_skip, rsp_err}, {1'b1, ~v[b], 1'b0})
    end
  endtask

  task automatic flag_clear();
    @(posedge clk);
    flag_event <= {8'hFF, 8'hC3};
    @(posedge clk);
    flag_event <= '0;
    #1;
    `CHK(flag_q, {8'hF0, 8'hC3})
    xfer(IOB_SET_IO_BIT_OP, 16'h0014, 0, 8'h00);
    `CHK({c_wr, flag_q[0]}, {1'b0, 8'hC2})
    xfer(IOB_CLEAR_IO_BIT_OP, 16'h0014, 1, 8'h00);
    `CHK(flag_q[0], 8'hC2)
    // hardware set in the same cycle as a written one must keep the flag
    @(posedge clk);
    flag_event <= {8'h00, 8'h80};
    xfer(IOB_SET_IO_BIT_OP, 16'h0014, 7, 8'h00);
    @(posedge clk);
    flag_event <= '0;
    #1;
    `CHK(flag_q[0], 8'hC2)
    // every bit of this register is defined, so no unused position is written as one
    xfer(IOB_IO_WRITE, 16'h0015, 0, 8'h3C);
    xfer(IOB_DIRECT_DATA_LOAD, 16'h0035, 0, 8'h00);
    `CHK(rsp_rdata, 8'hCC)
  endtask

  // reset in mid-run: flags and response clear at once, ready comes straight back
  task automatic reset_midrun();
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    `CHK({req_ready, rsp_valid, rsp_err, rsp_rdata, flag_q}, {3'h4, 8'h00, 16'h0000})
    @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic direct_and_map();
    xfer(IOB_DIRECT_DATA_STORE, 16'h0080, 0, 8'h3C);
    `CHK({c_wr, c_addr, c_mask, c_wdata}, {1'b1, 8'h80, 8'hFF, 8'h3C})
    xfer(IOB_DIRECT_DATA_LOAD, 16'h0080, 0, 8'h00);
    `CHK({c_rd, rsp_rdata}, {1'b1, 8'h3C})
    xfer(IOB_IO_WRITE, 16'h003F, 0, 8'h96);
    `CHK(c_addr, 8'h5F)
    xfer(IOB_DIRECT_DATA_LOAD, 16'h005F, 0, 8'h00);
    `CHK(rsp_rdata, 8'h96)
    xfer(IOB_DIRECT_DATA_STORE, 16'h001F, 0, 8'h11);
    `CHK({rsp_err, c_wr, c_rd, rsp_rdata}, {3'h4, 8'h00})
    xfer(IOB_DIRECT_DATA_LOAD, 16'h0100, 0, 8'h00);
    `CHK({rsp_err, c_wr, c_rd, rsp_rdata}, {3'h4, 8'h00})
    xfer(IOB_IO_READ, 16'h0040, 0, 8'h00);
    `CHK({rsp_err, c_wr, c_rd, rsp_rdata}, {3'h4, 8'h00})
  endtask

  initial
  begin
    rst_n       = 1'b0;
    req_valid   = 1'b0;
    req_op      = IOB_IO_READ;
    req_addr    = 16'h0000;
    req_bit     = 3'h0;
    req_wdata   = 8'h00;
    flag_event  = '0;
    n_errors    = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK({req_ready, rsp_valid, per_wr, per_rd, flag_q}, {4'h8, 16'h0000})
    set_clear_bits();
    bit_ops_refused();
    skip_tests();
    flag_clear();
    reset_midrun();
    direct_and_map();
    report_and_stop();
  end
endmodule

`default_nettype wire
